// ===== logic/delay_counter.v
`timescale 1ns/1ps
`default_nettype none

module delay_counter #(
  parameter WIDTH = 20
) (
  input wire clk_sys_i, // Clock
  input wire arst_n_i, // Async reset, low
  input wire load_i, // Start a count
  input wire abort_i, // Stop without done
  input wire [WIDTH-1:0] count_i, // Number of ticks
  input wire [3:0] exp_i, // Tick is 2**exp cycles
  output reg busy_o, // Counting
  output reg done_o // Expiry pulse
);

  reg [WIDTH-1:0] cnt_q;
  reg [15:0] pre_q;
  reg [3:0] exp_q;
  wire [15:0] pre_top;
  wire tick;

  assign pre_top = (16'h0001 << exp_q) - 16'h0001;
  assign tick = (pre_q == pre_top);

  always @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_q <= {WIDTH{1'b0}};
      pre_q <= 16'h0000;
      exp_q <= 4'h0;
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (abort_i) begin
        busy_o <= 1'b0;
      end else if (load_i) begin
        cnt_q <= count_i;
        exp_q <= exp_i;
        pre_q <= 16'h0000;
        busy_o <= (count_i != {WIDTH{1'b0}});
        // A zero count expires at once
        done_o <= (count_i == {WIDTH{1'b0}});
      end else if (busy_o) begin
        pre_q <= tick ? 16'h0000 : pre_q + 16'h0001;
        if (tick) begin
          cnt_q <= cnt_q - {{(WIDTH-1){1'b0}}, 1'b1};
          if (cnt_q == {{(WIDTH-1){1'b0}}, 1'b1}) begin
            busy_o <= 1'b0;
            done_o <= 1'b1;
          end
        end
      end
    end
  end

endmodule

`default_nettype wire

// ===== logic/phase_sync_map.vh
`ifndef PHASE_SYNC_MAP_VH
`define PHASE_SYNC_MAP_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_CTRL 8'h00
`define OFS_CONFIG 8'h04
`define OFS_DELAY 8'h08
`define OFS_STATUS 8'h0c

// ----------------------------------------
// Control fields
// ----------------------------------------
`define CTRL_SYNC_EN 0
`define CTRL_PIN_MASK 1
`define CTRL_FREQUENCY_CALIBRATION_ENABLE 2
`define CTRL_PWRDN 3
`define CTRL_CAL_BYPASS 4
`define CTRL_SRESET 5
`define CTRL_CAL_GO 6
`define CTRL_RST 5'h0a

// ----------------------------------------
// Configuration fields
// ----------------------------------------
`define CFG_REFERENCE_MULTIPLIER_LSB 0
`define CFG_REFERENCE_MULTIPLIER_MSB 2
`define CFG_OUT_INT 3
`define CFG_CHDIV_BYP 4
`define CFG_REF_INT 5
`define CFG_FRAC 6
`define CFG_REF_OK 7
`define CFG_RST 8'h99
`define REFERENCE_MULTIPLIER_ONE 3'h1

// ----------------------------------------
// Delay register fields
// ----------------------------------------
`define DLY_CNT_MSB 19
`define DLY_DIV_LSB 24
`define DLY_DIV_MSB 27

// ----------------------------------------
// Category codes
// ----------------------------------------
`define CAT_1 3'h1
`define CAT_2 3'h2
`define CAT_3 3'h3
`define CAT_NONE 3'h4

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_PS 5000
`define ALIGN_DELAY_US 500
`define ALIGN_DELAY_CYC ((`ALIGN_DELAY_US * 1000000) / `CLK_PERIOD_PS)

`endif

// ===== logic/synth_phase_sync_control.v
// Function
// - Request is re-timed to the next reference clock edge before alignment.
// - Deterministic delay only after calibration, settling and modulator delay expiry.
// - Category 1 aligns with sync disabled and no request.
// - Category 2 needs sync enabled and any rising edge on request pin.
// - Request pin ignored while pin mask is set.
// - Alignment times out after count times 2**divider reference cycles.
// - Programmed delay is an upper bound; engine may finish early.
// - Category 1: multiplier one, integer output multiple, channel divider bypassed.
// - Category 1 phase holds over power cycle, calibration, reset and reprogram.
// - Category 1 without calibration may shift after power-down; only reset fixes.
// - Category 1 without calibration stays deterministic across frequency change.
//
// Added by the designer: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "phase_sync_map.vh"

module synth_phase_sync_control #(
  parameter CNT_WIDTH = 20,
  parameter CAL_CYCLES = 400,
  parameter SETTLE_CYCLES = 1000,
  parameter DELAY_RESET = `ALIGN_DELAY_CYC
) (
  input wire clk_sys_i, // Reference-derived clock
  input wire arst_n_i, // Async reset, low
  input wire hsel_i, // AHB select
  input wire [7:0] haddr_i, // AHB address
  input wire [1:0] htrans_i, // AHB transfer type
  input wire hwrite_i, // AHB write
  input wire [2:0] hsize_i, // AHB size
  input wire [31:0] hwdata_i, // AHB write data
  input wire hready_i, // AHB ready in
  output wire hreadyout_o, // AHB ready out
  output wire hresp_o, // AHB response
  output reg [31:0] hrdata_o, // AHB read data
  input wire align_request_pin_i, // Alignment request pin
  input wire engine_done_i, // Alignment engine finished early
  output reg align_start_o, // Re-timed request pulse
  output reg vco_cal_o, // Calibration running
  output reg modulator_reset_o, // Modulator reset held
  output reg powerdown_o, // Power-down level
  output reg phase_locked_o // Output phase deterministic
);

  localparam [4:0] ST_IDLE = 5'b00001;
  localparam [4:0] ST_CAL = 5'b00010;
  localparam [4:0] ST_SETTLE = 5'b00100;
  localparam [4:0] ST_READY = 5'b01000;
  localparam [4:0] ST_ALIGN = 5'b10000;

  // ----------------------------------------
  // Bus slave
  // ----------------------------------------
  reg wr_pend_q;
  reg [7:0] wr_addr_q;
  reg [4:0] ctrl_q;
  reg [7:0] config_q;
  reg [CNT_WIDTH-1:0] mash_cnt_q;
  reg [3:0] cal_div_q;
  reg [4:0] state_q;
  reg [2:0] category;
  reg req_pin_q;
  reg req_prev_q;
  reg resync_q;
  reg shift_q;
  reg timeout_q;
  reg early_q;
  reg [31:0] rdata;
  wire addr_ok;
  wire wr_ctrl;
  wire wr_cfg;
  wire sreset;
  wire cal_go;
  wire sync_en;
  wire pin_mask;
  wire frequency_calibration_enable;
  wire cal_bypass;
  wire req_edge;
  wire req_ok;
  wire cnt_done;
  wire mash_done;
  reg cnt_load;
  reg [CNT_WIDTH-1:0] cnt_val;

  assign addr_ok = hsel_i & htrans_i[1] & hready_i;
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign wr_ctrl = wr_pend_q & (wr_addr_q == `OFS_CTRL);
  assign wr_cfg = wr_pend_q & (wr_addr_q == `OFS_CONFIG);
  assign sreset = wr_ctrl & hwdata_i[`CTRL_SRESET];
  assign cal_go = wr_ctrl & hwdata_i[`CTRL_CAL_GO];
  assign sync_en = ctrl_q[`CTRL_SYNC_EN];
  assign pin_mask = ctrl_q[`CTRL_PIN_MASK];
  assign frequency_calibration_enable = ctrl_q[`CTRL_FREQUENCY_CALIBRATION_ENABLE];
  assign cal_bypass = ctrl_q[`CTRL_CAL_BYPASS];

  always @* begin
    case (haddr_i)
      `OFS_CTRL: rdata = {27'h0000000, ctrl_q};
      `OFS_CONFIG: rdata = {24'h000000, config_q};
      `OFS_DELAY: rdata = {4'h0, cal_div_q, {(24-CNT_WIDTH){1'b0}}, mash_cnt_q};
      `OFS_STATUS: rdata = {16'h0000, 3'h0, state_q, early_q, timeout_q, shift_q,
                            resync_q, phase_locked_o, category};
      default: rdata = 32'h00000000;
    endcase
  end

  // Read data registered in address phase, so zero wait states
  always @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      hrdata_o <= 32'h00000000;
    end else begin
      wr_pend_q <= addr_ok & hwrite_i;
      if (addr_ok) begin
        wr_addr_q <= haddr_i;
      end
      if (addr_ok & ~hwrite_i) begin
        hrdata_o <= rdata;
      end
    end
  end

  // Software reset returns settings to defaults; reprogramming follows
  always @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl_q <= `CTRL_RST;
      config_q <= `CFG_RST;
      mash_cnt_q <= DELAY_RESET[CNT_WIDTH-1:0];
      cal_div_q <= 4'h0;
    end else if (sreset) begin
      ctrl_q <= `CTRL_RST;
      config_q <= `CFG_RST;
      mash_cnt_q <= DELAY_RESET[CNT_WIDTH-1:0];
      cal_div_q <= 4'h0;
    end else if (wr_pend_q) begin
      case (wr_addr_q)
        `OFS_CTRL: ctrl_q <= hwdata_i[4:0];
        `OFS_CONFIG: config_q <= hwdata_i[7:0];
        `OFS_DELAY: begin
          mash_cnt_q <= hwdata_i[CNT_WIDTH-1:0];
          cal_div_q <= hwdata_i[`DLY_DIV_MSB:`DLY_DIV_LSB];
        end
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // Category decode
  // ----------------------------------------
  always @* begin
    if (config_q[`CFG_REFERENCE_MULTIPLIER_MSB:`CFG_REFERENCE_MULTIPLIER_LSB] == `REFERENCE_MULTIPLIER_ONE && config_q[`CFG_OUT_INT] &&
        config_q[`CFG_CHDIV_BYP]) begin
      category = `CAT_1;
    end else if (config_q[`CFG_REFERENCE_MULTIPLIER_MSB:`CFG_REFERENCE_MULTIPLIER_LSB] == `REFERENCE_MULTIPLIER_ONE &&
                 (config_q[`CFG_OUT_INT] || config_q[`CFG_REF_INT])) begin
      category = `CAT_2;
    end else if (config_q[`CFG_REF_OK]) begin
      category = `CAT_3;
    end else begin
      category = `CAT_NONE;
    end
  end

  // ----------------------------------------
  // Request pin
  // ----------------------------------------
  // Only a fresh low-to-high change counts, so a held-high pin fires once
  assign req_edge = req_pin_q & ~req_prev_q;
  assign req_ok = req_edge & ~pin_mask & sync_en &
                  (category == `CAT_2 || category == `CAT_3) &
                  (~cal_bypass | frequency_calibration_enable);

  always @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      req_pin_q <= 1'b0;
      req_prev_q <= 1'b0;
    end else begin
      req_pin_q <= align_request_pin_i;
      req_prev_q <= req_pin_q;
    end
  end

  // ----------------------------------------
  // Counters
  // ----------------------------------------
  delay_counter #(
    .WIDTH(CNT_WIDTH)
  ) u_settle (
    .clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i),
    .load_i(cnt_load),
    // Abort on the setting, not its copy, so the power-up cycle can still load
    .abort_i(ctrl_q[`CTRL_PWRDN] | sreset),
    .count_i(cnt_val),
    .exp_i(4'h0),
    .busy_o(),
    .done_o(cnt_done)
  );

  // Modulator delay counts only for a nonzero numerator
  delay_counter #(
    .WIDTH(CNT_WIDTH)
  ) u_mash (
    .clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i),
    .load_i(align_start_o),
    .abort_i(ctrl_q[`CTRL_PWRDN] | sreset | (state_q == ST_ALIGN && engine_done_i)),
    .count_i(config_q[`CFG_FRAC] ? mash_cnt_q : {CNT_WIDTH{1'b0}}),
    .exp_i(cal_div_q),
    .busy_o(),
    .done_o(mash_done)
  );

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always @* begin
    cnt_load = 1'b0;
    cnt_val = SETTLE_CYCLES[CNT_WIDTH-1:0];
    case (state_q)
      ST_IDLE: begin
        if (~ctrl_q[`CTRL_PWRDN] & (cal_go | powerdown_o)) begin
          cnt_load = 1'b1;
          cnt_val = cal_bypass ? SETTLE_CYCLES[CNT_WIDTH-1:0] : CAL_CYCLES[CNT_WIDTH-1:0];
        end
      end
      ST_CAL: cnt_load = cnt_done;
      ST_READY: begin
        if (cal_go) begin
          cnt_load = 1'b1;
          cnt_val = cal_bypass ? SETTLE_CYCLES[CNT_WIDTH-1:0] : CAL_CYCLES[CNT_WIDTH-1:0];
        end
      end
      default: ;
    endcase
  end

  always @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_q <= ST_IDLE;
      powerdown_o <= 1'b0;
      vco_cal_o <= 1'b0;
      modulator_reset_o <= 1'b0;
      align_start_o <= 1'b0;
      phase_locked_o <= 1'b0;
      resync_q <= 1'b0;
      shift_q <= 1'b0;
      timeout_q <= 1'b0;
      early_q <= 1'b0;
    end else begin
      powerdown_o <= ctrl_q[`CTRL_PWRDN];
      align_start_o <= 1'b0;
      if (sreset) begin
        state_q <= ST_IDLE;
        vco_cal_o <= 1'b0;
        modulator_reset_o <= 1'b0;
        phase_locked_o <= 1'b0;
        resync_q <= 1'b0;
        shift_q <= 1'b0;
      end else if (powerdown_o & ctrl_q[`CTRL_PWRDN]) begin
        state_q <= ST_IDLE;
        vco_cal_o <= 1'b0;
        modulator_reset_o <= 1'b0;
        phase_locked_o <= 1'b0;
        if (category == `CAT_1 && cal_bypass) begin
          shift_q <= 1'b1;
        end
      end else begin
        case (state_q)
          ST_IDLE: begin
            if (cnt_load) begin
              state_q <= cal_bypass ? ST_SETTLE : ST_CAL;
              vco_cal_o <= ~cal_bypass;
            end
          end
          ST_CAL: begin
            if (cnt_done) begin
              vco_cal_o <= 1'b0;
              state_q <= ST_SETTLE;
            end
          end
          ST_SETTLE: begin
            if (cnt_done) begin
              state_q <= ST_READY;
              // Category 1 is deterministic with no request at all
              phase_locked_o <= (category == `CAT_1) & ~shift_q;
              resync_q <= (category == `CAT_2 || category == `CAT_3);
            end
          end
          ST_READY: begin
            if (cnt_load) begin
              state_q <= cal_bypass ? ST_SETTLE : ST_CAL;
              vco_cal_o <= ~cal_bypass;
              phase_locked_o <= 1'b0;
            end else if (req_ok) begin
              state_q <= ST_ALIGN;
              align_start_o <= 1'b1;
              modulator_reset_o <= config_q[`CFG_FRAC];
              phase_locked_o <= 1'b0;
              timeout_q <= 1'b0;
              early_q <= 1'b0;
            end
          end
          ST_ALIGN: begin
            if (engine_done_i && !align_start_o) begin
              state_q <= ST_READY;
              modulator_reset_o <= 1'b0;
              phase_locked_o <= 1'b1;
              resync_q <= 1'b0;
              early_q <= 1'b1;
            end else if (mash_done) begin
              state_q <= ST_READY;
              modulator_reset_o <= 1'b0;
              phase_locked_o <= 1'b1;
              resync_q <= 1'b0;
              timeout_q <= config_q[`CFG_FRAC];
            end
          end
          default: state_q <= ST_IDLE;
        endcase
        // Frequency change outside category 1 with calibration bypassed loses alignment
        if (wr_cfg && !(category == `CAT_1 && cal_bypass)) begin
          phase_locked_o <= 1'b0;
          resync_q <= 1'b1;
        end
      end
    end
  end

endmodule

`default_nettype wire

// ===== tb/sync_source.sv
`timescale 1ns/1ps
`default_nettype none

module sync_source (
  input wire logic clk_i, // Reference clock
  input wire logic arst_n_i, // Reset, low
  input wire logic fire_i, // Send one request
  input wire logic align_start_i, // Alignment began
  input wire logic [7:0] done_lat_i, // Engine latency, 0 never
  output logic pin_o = 1'b0, // Request pin
  output logic done_o = 1'b0 // Engine finished
);
  // ----------------------------------------
  // Request pulse and engine
  // ----------------------------------------
  logic [1:0] hold_q = 2'h0;
  logic [7:0] lat_q = 8'h0;
  // Pulse launched just after a reference edge, then back low
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      hold_q <= 2'h0;
      lat_q <= 8'h0;
      pin_o <= 1'b0;
      done_o <= 1'b0;
    end else begin
      if (fire_i)
        hold_q <= 2'h3;
      else if (hold_q != 2'h0)
        hold_q <= hold_q - 2'h1;
      pin_o <= (hold_q != 2'h0);
      if (align_start_i)
        lat_q <= done_lat_i;
      else if (lat_q != 8'h0)
        lat_q <= lat_q - 8'h1;
      done_o <= (lat_q == 8'h1);
    end
  end
endmodule
`default_nettype wire

// ===== tb/synth_phase_sync_control_sva.sv
`timescale 1ns/1ps
`default_nettype none

module synth_phase_sync_control_sva #(
  parameter int CAL_CYCLES = 400,
  parameter int ALIGN_MAX = 64
) (
  input wire logic clk_sys_i, // Clock
  input wire logic arst_n_i, // Reset, low
  input wire logic hreadyout_o, // Bus ready
  input wire logic hresp_o, // Bus response
  input wire logic align_request_pin_i, // Request pin
  input wire logic engine_done_i, // Engine done
  input wire logic align_start_o, // Start pulse
  input wire logic vco_cal_o, // Calibrating
  input wire logic modulator_reset_o, // Aligning
  input wire logic powerdown_o, // Powered down
  input wire logic phase_locked_o // Deterministic
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);
  // ----------------------------------------
  // Run lengths
  // ----------------------------------------
  logic [15:0] cal_q;
  logic [15:0] mod_q;
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cal_q <= 16'h0;
      mod_q <= 16'h0;
    end else begin
      cal_q <= vco_cal_o ? cal_q + 16'h1 : 16'h0;
      mod_q <= modulator_reset_o ? mod_q + 16'h1 : 16'h0;
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  property p_bus_okay;
    hreadyout_o && !hresp_o;
  endproperty
  a_bus_okay: assert property (p_bus_okay) else $error("bus not ready or not okay");
  property p_retime;
    $rose(align_start_o) |-> $past(align_request_pin_i, 2) && !$past(align_request_pin_i, 3);
  endproperty
  a_retime: assert property (p_retime) else $error("start not retimed");
  property p_start_pulse;
    align_start_o |=> !align_start_o;
  endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("start too long");
  property p_start_ready;
    align_start_o |-> !vco_cal_o && !powerdown_o;
  endproperty
  a_start_ready: assert property (p_start_ready) else $error("start while not ready");
  property p_lock_cause;
    $rose(phase_locked_o) |-> !vco_cal_o && !powerdown_o && !align_start_o;
  endproperty
  a_lock_cause: assert property (p_lock_cause) else $error("lock too early");
  property p_early_done;
    modulator_reset_o && engine_done_i |-> ##[1:2] phase_locked_o;
  endproperty
  a_early_done: assert property (p_early_done) else $error("early finish ignored");
  property p_align_bound;
    mod_q <= ALIGN_MAX;
  endproperty
  a_align_bound: assert property (p_align_bound) else $error("alignment overran");
  property p_cal_length;
    $fell(vco_cal_o) |-> cal_q >= CAL_CYCLES - 1 && cal_q <= CAL_CYCLES + 1;
  endproperty
  a_cal_length: assert property (p_cal_length) else $error("calibration length");
endmodule

bind synth_phase_sync_control synth_phase_sync_control_sva #(
  .CAL_CYCLES(CAL_CYCLES)
) i_synth_phase_sync_control_sva (
  .clk_sys_i(clk_sys_i),
  .arst_n_i(arst_n_i),
  .hreadyout_o(hreadyout_o),
  .hresp_o(hresp_o),
  .align_request_pin_i(align_request_pin_i),
  .engine_done_i(engine_done_i),
  .align_start_o(align_start_o),
  .vco_cal_o(vco_cal_o),
  .modulator_reset_o(modulator_reset_o),
  .powerdown_o(powerdown_o),
  .phase_locked_o(phase_locked_o)
);
`default_nettype wire

// ===== tb/synth_phase_sync_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "phase_sync_map.vh"

module synth_phase_sync_control_tb;
  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  logic clk_sys_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic hsel_i = 1'b0;
  logic [7:0] haddr_i = 8'h00;
  logic [1:0] htrans_i = 2'h0;
  logic hwrite_i = 1'b0;
  logic [31:0] hwdata_i = 32'h0;
  logic fire_q = 1'b0;
  logic [7:0] lat_q = 8'h00;
  logic [31:0] rd;
  wire logic hreadyout_o, hresp_o, pin, done;
  wire logic align_start_o, vco_cal_o, modulator_reset_o, powerdown_o, phase_locked_o;
  wire logic [31:0] hrdata_o;
  int err_total = 0;
  int checks_done = 0;
  int starts = 0;
  int n;
  // Config in, category out
  logic [10:0] rows [6] = '{{8'h89, 3'h2}, {8'ha1, 3'h2}, {8'h91, 3'h3},
                            {8'h82, 3'h3}, {8'h02, 3'h4}, {8'h99, 3'h1}};

  always #2.5 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) if (align_start_o === 1'b1) starts++;

  synth_phase_sync_control #(.CAL_CYCLES(10), .SETTLE_CYCLES(20)) i_synth_phase_sync_control (
    .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2), .hwdata_i(hwdata_i),
    .hready_i(hreadyout_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
    .hrdata_o(hrdata_o), .align_request_pin_i(pin), .engine_done_i(done),
    .align_start_o(align_start_o), .vco_cal_o(vco_cal_o),
    .modulator_reset_o(modulator_reset_o), .powerdown_o(powerdown_o),
    .phase_locked_o(phase_locked_o));
  sync_source i_sync_source (.clk_i(clk_sys_i), .arst_n_i(arst_n_i), .fire_i(fire_q),
    .align_start_i(align_start_o), .done_lat_i(lat_q), .pin_o(pin), .done_o(done));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk_sys_i);
    hsel_i <= 1'b1;
    htrans_i <= 2'h2;
    haddr_i <= a;
    hwrite_i <= wr;
    do @(posedge clk_sys_i); while (hreadyout_o !== 1'b1);
    hsel_i <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= wd;
    do @(posedge clk_sys_i); while (hreadyout_o !== 1'b1);
    rd = hrdata_o;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task automatic fire(input logic [7:0] lat);
    lat_q <= lat;
    fire_q <= 1'b1;
    @(posedge clk_sys_i);
    fire_q <= 1'b0;
  endtask
  task automatic wait_lock;
    repeat (200) if (phase_locked_o !== 1'b1) @(posedge clk_sys_i);
  endtask
  task automatic wait_ready;
    repeat (100) begin
      bus(1'b0, `OFS_STATUS, 32'h0);
      if (rd[11] === 1'b1)
        break;
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    #200000;
    err_total++;
    summarize();
  end
  initial begin
    repeat (3) @(posedge clk_sys_i);
    arst_n_i <= 1'b1;
    rdchk(`OFS_CTRL, 32'h0a);
    rdchk(`OFS_DELAY, 32'h000186a0);
    rdchk(8'h10, 32'h0);
    chk(powerdown_o, 1'b1);
    $display("reset test done");
    for (int i = 0; i < 6; i++) begin
      bus(1'b1, `OFS_CONFIG, {24'h0, rows[i][10:3]});
      // Still powered down, so the state field reads idle
      rdchk(`OFS_STATUS, {19'h0, 5'h01, 5'h00, rows[i][2:0]});
    end
    $display("category table done");
    bus(1'b1, `OFS_CTRL, 32'h00);
    wait_lock();
    chk(phase_locked_o, 1'b1);
    bus(1'b1, `OFS_CTRL, 32'h08);
    bus(1'b1, `OFS_CTRL, 32'h00);
    wait_lock();
    chk({phase_locked_o, starts[0]}, 2'h2);
    bus(1'b1, `OFS_CTRL, 32'h40);
    @(posedge clk_sys_i);
    chk({vco_cal_o, phase_locked_o}, 2'h2);
    wait_lock();
    chk(phase_locked_o, 1'b1);
    $display("category 1 test done");
    bus(1'b1, `OFS_DELAY, 32'h02000008);
    bus(1'b1, `OFS_CONFIG, 32'hc2);
    bus(1'b1, `OFS_CTRL, 32'h0b);
    bus(1'b1, `OFS_CTRL, 32'h03);
    wait_ready();
    chk({rd[4], phase_locked_o}, 2'h2);
    fire(8'h03);
    repeat (8) @(posedge clk_sys_i);
    chk(starts, 0);
    bus(1'b1, `OFS_CTRL, 32'h01);
    fire(8'h03);
    wait_lock();
    chk(starts, 1);
    rdchk(`OFS_STATUS, 32'h088b);
    fire(8'h00);
    repeat (10) if (modulator_reset_o !== 1'b1) @(posedge clk_sys_i);
    n = 0;
    while (modulator_reset_o === 1'b1 && n < 100) begin
      @(posedge clk_sys_i);
      n++;
    end
    chk(n >= 31 && n <= 35, 1'b1);
    bus(1'b0, `OFS_STATUS, 32'h0);
    chk(rd[6], 1'b1);
    $display("category 3 test done");
    bus(1'b1, `OFS_CTRL, 32'h20);
    rdchk(`OFS_CONFIG, 32'h99);
    bus(1'b1, `OFS_CTRL, 32'h10);
    wait_lock();
    bus(1'b1, `OFS_CONFIG, 32'h99);
    @(posedge clk_sys_i);
    chk(phase_locked_o, 1'b1);
    bus(1'b1, `OFS_CTRL, 32'h18);
    bus(1'b1, `OFS_CTRL, 32'h10);
    wait_ready();
    chk(rd[5], 1'b1);
    bus(1'b1, `OFS_CTRL, 32'h20);
    rdchk(`OFS_CTRL, 32'h0a);
    bus(1'b0, `OFS_STATUS, 32'h0);
    chk(rd[5], 1'b0);
    $display("bypass test done");
    bus(1'b1, `OFS_CONFIG, 32'h89);
    bus(1'b1, `OFS_CTRL, 32'h11);
    wait_ready();
    fire(8'h00);
    repeat (8) @(posedge clk_sys_i);
    chk(starts, 2);
    bus(1'b1, `OFS_CTRL, 32'h15);
    fire(8'h00);
    wait_lock();
    chk(starts, 3);
    rdchk(`OFS_STATUS, 32'h080a);
    $display("calibration enable test done");
    summarize();
  end
endmodule
`default_nettype wire
